// >>> logic/adc_ctrl_dev.sv
// converter end: control byte decode, input mux steering, result shift-out
// ==========================================
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module adc_ctrl_dev #(
  parameter int FOUR_INPUT = 0,
  parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  adc_link_if.dev link,
  input wire logic [7:0] sample_code,
  input wire logic sample_negative,
  output logic [2:0] mux_pos,
  output logic [2:0] mux_neg,
  output logic mux_neg_common,
  output logic polarity_select,
  output logic input_config_select,
  output logic power_select,
  output logic clock_mode_select,
  output logic track,
  output logic conv_start
);
  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_CONV, ST_OUT} state_t;

  // ==========================================
  // pin synchronisers
  // [0] chip select, [1] serial clock, [2] serial data
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_prev_reg;
  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
      sclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.din, link.sclk, link.cs_n};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[1];
    end
  end

  assign cs_low = ~sync2_reg[0];
  assign sclk_rise = sync2_reg[1] & ~sclk_prev_reg & cs_low;
  assign sclk_fall = ~sync2_reg[1] & sclk_prev_reg;

  // ==========================================
  // mux decode
  function automatic logic [5:0] decode_mux(input logic [7:0] b);
    logic hi;
    logic mid;
    logic lo;
    logic [2:0] pos;
    logic [2:0] neg;
    hi = b[adc_link_pkg::SEL_HI_BIT];
    mid = b[adc_link_pkg::SEL_MID_BIT];
    lo = b[adc_link_pkg::SEL_LO_BIT];
    if (FOUR_INPUT != 0) begin
      pos = {1'b0, mid, hi};
      neg = b[adc_link_pkg::CFG_BIT] ? 3'h0 : {1'b0, mid, ~hi};
    end else if (b[adc_link_pkg::CFG_BIT]) begin
      pos = {mid, lo, hi};
      neg = 3'h0;
    end else begin
      pos = {mid, lo, hi};
      neg = {mid, lo, ~hi};
    end
    return {pos, neg};
  endfunction

  // ==========================================
  // control sequencer
  state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] result_reg, result_next;
  logic [3:0] out_cnt_reg, out_cnt_next;
  logic skip_reg, skip_next;
  logic [15:0] conv_cnt_reg, conv_cnt_next;
  logic dout_reg, dout_next;
  logic end_of_conversion_strobe_reg, end_of_conversion_strobe_next;
  logic track_reg, track_next;
  logic start_reg, start_next;
  logic [5:0] mux_reg, mux_next;
  logic ext_mode;

  assign ext_mode = ctrl_reg[adc_link_pkg::CLK_MODE_BIT];

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    ctrl_next = ctrl_reg;
    result_next = result_reg;
    out_cnt_next = out_cnt_reg;
    skip_next = skip_reg;
    conv_cnt_next = conv_cnt_reg;
    dout_next = dout_reg;
    end_of_conversion_strobe_next = end_of_conversion_strobe_reg;
    track_next = track_reg;
    start_next = 1'b0;
    mux_next = mux_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sclk_fall) begin
          dout_next = 1'b0;
        end
        // leading zeros do nothing
        if (sclk_rise && sync2_reg[2]) begin
          shift_next = 8'h01;
          bit_cnt_next = 4'h1;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sclk_rise && bit_cnt_reg < 4'(adc_link_pkg::CTRL_BITS)) begin
          shift_next = {shift_reg[6:0], sync2_reg[2]};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        if (sclk_fall && bit_cnt_reg == 4'(adc_link_pkg::TRACK_AFTER_BIT)) begin
          track_next = 1'b1;
        end
        if (sclk_fall && bit_cnt_reg == 4'(adc_link_pkg::CTRL_BITS)) begin
          // whole byte applied at once, never a half-updated mux
          ctrl_next = shift_reg;
          mux_next = decode_mux(shift_reg);
          track_next = 1'b0;
          start_next = 1'b1;
          if (shift_reg[adc_link_pkg::POL_BIT] && !shift_reg[adc_link_pkg::CFG_BIT] && sample_negative) begin
            result_next = 8'h00;
          end else begin
            result_next = sample_code;
          end
          out_cnt_next = 4'h0;
          skip_next = 1'b1;
          conv_cnt_next = 16'h0000;
          if (shift_reg[adc_link_pkg::CLK_MODE_BIT]) begin
            end_of_conversion_strobe_next = 1'b1;
            state_next = ST_OUT;
          end else begin
            end_of_conversion_strobe_next = 1'b0;
            state_next = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        // chip select high does not disturb an internal conversion
        conv_cnt_next = conv_cnt_reg + 16'h0001;
        if (conv_cnt_reg == 16'(CONV_CYCLES - 1)) begin
          end_of_conversion_strobe_next = 1'b1;
          state_next = ST_OUT;
        end
      end
      ST_OUT: begin
        if (sclk_fall) begin
          if (skip_reg) begin
            skip_next = 1'b0;
          end else begin
            dout_next = result_reg[7];
            result_next = {result_reg[6:0], 1'b0};
            out_cnt_next = out_cnt_reg + 4'h1;
            if (ext_mode) begin
              end_of_conversion_strobe_next = 1'b0;
            end
            if (out_cnt_reg == 4'(adc_link_pkg::RESULT_BITS - 1)) begin
              state_next = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // dropping chip select aborts a byte or an external readout
    if (!cs_low && (state_reg == ST_SHIFT || (state_reg == ST_OUT && ext_mode))) begin
      state_next = ST_IDLE;
      track_next = 1'b0;
      dout_next = 1'b0;
      if (ext_mode) begin
        end_of_conversion_strobe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ctrl_reg <= 8'h00;
      result_reg <= 8'h00;
      out_cnt_reg <= 4'h0;
      skip_reg <= 1'b0;
      conv_cnt_reg <= 16'h0000;
      dout_reg <= 1'b0;
      end_of_conversion_strobe_reg <= 1'b0;
      track_reg <= 1'b0;
      start_reg <= 1'b0;
      mux_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      ctrl_reg <= ctrl_next;
      result_reg <= result_next;
      out_cnt_reg <= out_cnt_next;
      skip_reg <= skip_next;
      conv_cnt_reg <= conv_cnt_next;
      dout_reg <= dout_next;
      end_of_conversion_strobe_reg <= end_of_conversion_strobe_next;
      track_reg <= track_next;
      start_reg <= start_next;
      mux_reg <= mux_next;
    end
  end

  // ==========================================
  // outputs
  assign link.dout = dout_reg;
  assign link.dout_oe = cs_low;
  // internal mode keeps the strobe driven with chip select high
  assign link.end_of_conversion_strobe = end_of_conversion_strobe_reg;
  assign link.end_of_conversion_strobe_oe = cs_low | ~ext_mode;
  assign mux_pos = mux_reg[5:3];
  assign mux_neg = mux_reg[2:0];
  assign mux_neg_common = ctrl_reg[adc_link_pkg::CFG_BIT];
  assign polarity_select = ctrl_reg[adc_link_pkg::POL_BIT];
  assign input_config_select = ctrl_reg[adc_link_pkg::CFG_BIT];
  assign power_select = ctrl_reg[adc_link_pkg::PWR_BIT];
  assign clock_mode_select = ctrl_reg[adc_link_pkg::CLK_MODE_BIT];
  assign track = track_reg;
  assign conv_start = start_reg;
endmodule // adc_ctrl_dev

// >>> shared/adc_link_pkg.sv
// constants shared by both ends of the serial converter link
package adc_link_pkg;
  // control byte layout
  localparam int CTRL_BITS = 8;
  localparam int START_BIT = 7;
  localparam int SEL_HI_BIT = 6;
  localparam int SEL_MID_BIT = 5;
  localparam int SEL_LO_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int CFG_BIT = 2;
  localparam int PWR_BIT = 1;
  localparam int CLK_MODE_BIT = 0;
  localparam int TRACK_AFTER_BIT = 6;
  localparam int RESULT_BITS = 8;
  // clocks after the byte: one skipped edge, then result, then zeros
  localparam int READ_CLOCKS = 16;
  localparam int RESULT_FIRST_RISE = 3;
  localparam int RESULT_MSB_POS = READ_CLOCKS - RESULT_FIRST_RISE;
  localparam int RESULT_LSB_POS = RESULT_MSB_POS - RESULT_BITS + 1;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACQ_TIME_NS = 1000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 25000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 20;
  // host register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RESULT_LSB = 8;
endpackage

// >>> shared/adc_link_if.sv
// five-wire link between the serial host and the converter control logic
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic end_of_conversion_strobe;
  logic end_of_conversion_strobe_oe;
  logic line_dout;
  logic line_end_of_conversion_strobe;
  // undriven lines read as low
  assign line_dout = dout & dout_oe;
  assign line_end_of_conversion_strobe = end_of_conversion_strobe & end_of_conversion_strobe_oe;
  modport dev (input cs_n, input sclk, input din, output dout, output dout_oe, output end_of_conversion_strobe, output end_of_conversion_strobe_oe);
  modport host (output cs_n, output sclk, output din, input line_dout, input line_end_of_conversion_strobe);
endinterface

// >>> logic/adc_link_host.sv
// serial host end: APB command registers, link clock divider, byte framing
`timescale 1ns/1ps
module adc_link_host #(
  parameter int SCLK_HALF = adc_link_pkg::SCLK_HALF_CYCLES,
  parameter int ACQ_CYCLES = adc_link_pkg::ACQ_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adc_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_WAIT} hstate_t;

  // ==========================================
  // link input synchronisers, [0] data, [1] strobe
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic end_of_conversion_strobe_prev_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      end_of_conversion_strobe_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.line_end_of_conversion_strobe, link.line_dout};
      sync2_reg <= sync1_reg;
      end_of_conversion_strobe_prev_reg <= sync2_reg[1];
    end
  end

  // ==========================================
  // apb decode
  logic access;
  logic mapped;
  logic start_req;
  logic busy;
  logic [7:0] result_reg, result_next;
  logic [31:0] rdata_reg, rdata_next;

  assign access = psel & penable;
  assign mapped = (paddr == adc_link_pkg::ADDR_CTRL) || (paddr == adc_link_pkg::ADDR_STATUS);
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign prdata = rdata_reg;
  // a start while busy is dropped
  assign start_req = access & pwrite & (paddr == adc_link_pkg::ADDR_CTRL) & ~busy;

  always_comb begin
    rdata_next = rdata_reg;
    if (psel && !penable) begin
      rdata_next = 32'h0000_0000;
      if (paddr == adc_link_pkg::ADDR_STATUS) begin
        rdata_next[adc_link_pkg::STAT_BUSY_BIT] = busy;
        rdata_next[adc_link_pkg::STAT_RESULT_LSB +: 8] = result_reg;
      end
    end
  end

  // ==========================================
  // link sequencer
  hstate_t state_reg, state_next;
  logic [7:0] tx_reg, tx_next;
  logic [15:0] rx_reg, rx_next;
  logic [15:0] half_reg, half_next;
  logic [15:0] acq_reg, acq_next;
  logic acq_run_reg, acq_run_next;
  logic [4:0] bit_reg, bit_next;
  logic read_phase_reg, read_phase_next;
  logic cs_n_reg, cs_n_next;
  logic sclk_reg, sclk_next;
  logic din_reg, din_next;
  logic [7:0] byte_fix;
  logic last_ctrl_bit;
  logic half_done;

  assign busy = (state_reg != H_IDLE);
  assign half_done = (half_reg == 16'(SCLK_HALF - 1));
  assign last_ctrl_bit = ~read_phase_reg & (bit_reg == 5'(adc_link_pkg::CTRL_BITS - 1));

  always_comb begin
    byte_fix = pwdata[7:0];
    byte_fix[adc_link_pkg::START_BIT] = 1'b1;
    if (!pwdata[adc_link_pkg::POL_BIT]) begin
      byte_fix[adc_link_pkg::CFG_BIT] = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    half_next = half_reg;
    acq_next = acq_reg;
    acq_run_next = acq_run_reg;
    bit_next = bit_reg;
    read_phase_next = read_phase_reg;
    cs_n_next = cs_n_reg;
    sclk_next = sclk_reg;
    din_next = din_reg;
    result_next = result_reg;
    if (acq_run_reg && acq_reg != 16'(ACQ_CYCLES)) begin
      acq_next = acq_reg + 16'h0001;
    end
    case (state_reg)
      H_IDLE: begin
        if (start_req) begin
          tx_next = {byte_fix[6:0], 1'b0};
          din_next = byte_fix[7];
          cs_n_next = 1'b0;
          half_next = 16'h0000;
          bit_next = 5'h00;
          read_phase_next = 1'b0;
          acq_run_next = 1'b0;
          acq_next = 16'h0000;
          state_next = H_LOW;
        end
      end
      H_LOW: begin
        half_next = half_reg + 16'h0001;
        if (half_done) begin
          sclk_next = 1'b1;
          half_next = 16'h0000;
          rx_next = {rx_reg[14:0], sync2_reg[0]};
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        if (!half_done) begin
          half_next = half_reg + 16'h0001;
        end
        // stretch the last control bit until the sample has settled
        if (half_done && (!last_ctrl_bit || acq_reg == 16'(ACQ_CYCLES))) begin
          sclk_next = 1'b0;
          half_next = 16'h0000;
          bit_next = bit_reg + 5'h01;
          din_next = tx_reg[7];
          tx_next = {tx_reg[6:0], 1'b0};
          state_next = H_LOW;
          if (!read_phase_reg && bit_reg == 5'(adc_link_pkg::TRACK_AFTER_BIT - 1)) begin
            acq_run_next = 1'b1;
          end
          if (last_ctrl_bit) begin
            acq_run_next = 1'b0;
            read_phase_next = 1'b1;
            bit_next = 5'h00;
            din_next = 1'b0;
            // din still holds the clock mode bit here
            if (!din_reg) begin
              state_next = H_WAIT;
            end
          end
          if (read_phase_reg && bit_reg == 5'(adc_link_pkg::READ_CLOCKS - 1)) begin
            cs_n_next = 1'b1;
            result_next = rx_reg[adc_link_pkg::RESULT_MSB_POS:adc_link_pkg::RESULT_LSB_POS];
            state_next = H_IDLE;
          end
        end
      end
      H_WAIT: begin
        // only a rise counts: a strobe left high by the last conversion is stale
        if (sync2_reg[1] && !end_of_conversion_strobe_prev_reg) begin
          half_next = 16'h0000;
          state_next = H_LOW;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= H_IDLE;
      tx_reg <= 8'h00;
      rx_reg <= 16'h0000;
      half_reg <= 16'h0000;
      acq_reg <= 16'h0000;
      acq_run_reg <= 1'b0;
      bit_reg <= 5'h00;
      read_phase_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      din_reg <= 1'b0;
      result_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      half_reg <= half_next;
      acq_reg <= acq_next;
      acq_run_reg <= acq_run_next;
      bit_reg <= bit_next;
      read_phase_reg <= read_phase_next;
      cs_n_reg <= cs_n_next;
      sclk_reg <= sclk_next;
      din_reg <= din_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.din = din_reg;
endmodule // adc_link_host

// >>> test/adc_link_checker.sv
// checker for the wires between serial host and converter
`timescale 1ns/1ps
module adc_link_checker #(
  parameter int ACQ_CYCLES = 250
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_oe,
  input wire logic line_end_of_conversion_strobe
);
  // ==========================================
  // link edge and control byte tracking
  logic sclk_reg;
  logic [4:0] rise_reg;
  logic [4:0] fall_reg;
  logic [7:0] byte_reg;
  logic [15:0] acq_reg;
  logic rise;
  logic fall;
  logic fall8;
  assign rise = sclk & ~sclk_reg;
  assign fall = ~sclk & sclk_reg;
  assign fall8 = fall & ~cs_n & (fall_reg == 5'h07);
  // counters saturate so long read phases cannot wrap into a false byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sclk_reg <= 1'b0;
      rise_reg <= 5'h00;
      fall_reg <= 5'h00;
      byte_reg <= 8'h00;
      acq_reg <= 16'h0000;
    end else begin
      sclk_reg <= sclk;
      if (cs_n) begin
        rise_reg <= 5'h00;
        fall_reg <= 5'h00;
      end else begin
        if (rise && rise_reg != 5'h1F) rise_reg <= rise_reg + 5'h01;
        if (rise && rise_reg < 5'h08) byte_reg <= {byte_reg[6:0], din};
        if (fall && fall_reg != 5'h1F) fall_reg <= fall_reg + 5'h01;
      end
      if (fall && !cs_n && fall_reg == 5'h05) acq_reg <= 16'h0000;
      else if (acq_reg != 16'hFFFF) acq_reg <= acq_reg + 16'h0001;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_FIRST_BIT_SET: assert property (rise && !cs_n && rise_reg == 5'h00 |-> din)
    else $error("first clocked bit of a byte is not one");
  AST_DIN_STEADY_AT_RISE: assert property (rise |-> $stable(din))
    else $error("data input moved at a link clock rise");
  AST_BIPOLAR_NEEDS_DIFF: assert property (rise && !cs_n && rise_reg == 5'h05 && !byte_reg[0] |-> !din)
    else $error("bipolar byte sent with single-ended input");
  AST_ACQ_WINDOW: assert property (fall8 |-> int'(acq_reg) >= ACQ_CYCLES - 1)
    else $error("acquisition window shorter than required");
  AST_EXT_STROBE: assert property (fall8 && byte_reg[0] |-> ##[1:8] line_end_of_conversion_strobe)
    else $error("external mode strobe did not pulse after the byte");
  AST_INT_STROBE_LOW: assert property (fall8 && !byte_reg[0] |-> ##[1:8] (!line_end_of_conversion_strobe) [*8])
    else $error("internal mode strobe not low at conversion start");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("link clock moving while deselected");
  AST_DOUT_RELEASED: assert property (cs_n [*5] |-> !dout_oe)
    else $error("data output still driven while deselected");
endmodule // adc_link_checker

// >>> test/tb.sv
// self-checking bench joining host end and converter end
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] sample_code = 8'h00;
  logic sample_negative = 1'b0;
  logic [2:0] mux_pos, mux_neg, mux_pos4, mux_neg4;
  logic mux_neg_common, mux_neg_common4, polarity_select, input_config_select;
  logic power_select, clock_mode_select, track, conv_start;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  // ==========================================
  // ends, second link feeds the four-input variant in parallel
  adc_link_if link();
  adc_link_if link4();
  assign link4.cs_n = link.cs_n;
  assign link4.sclk = link.sclk;
  assign link4.din = link.din;

  adc_link_host adc_link_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  adc_ctrl_dev #(.CONV_CYCLES(50)) adc_ctrl_dev_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
    .sample_code(sample_code), .sample_negative(sample_negative), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_neg_common(mux_neg_common), .polarity_select(polarity_select), .input_config_select(input_config_select),
    .power_select(power_select), .clock_mode_select(clock_mode_select), .track(track), .conv_start(conv_start));
  adc_ctrl_dev #(.FOUR_INPUT(1), .CONV_CYCLES(50)) adc_ctrl_dev4_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(link4), .sample_code(sample_code), .sample_negative(sample_negative), .mux_pos(mux_pos4),
    .mux_neg(mux_neg4), .mux_neg_common(mux_neg_common4), .polarity_select(), .input_config_select(),
    .power_select(), .clock_mode_select(), .track(), .conv_start());
  adc_link_checker #(.ACQ_CYCLES(adc_link_pkg::ACQ_CYCLES)) adc_link_checker_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din), .dout_oe(link.dout_oe),
    .line_end_of_conversion_strobe(link.line_end_of_conversion_strobe));

  always #2 clk_sys = ~clk_sys;

  // ==========================================
  // verdict and hang guard
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // about 20 frames of roughly 1200 cycles each
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================
  // bus and frame helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one conversion: host forces start bit and pairs bipolar with differential
  task automatic convert(input logic [7:0] w, input logic [7:0] code, input logic neg);
    logic [7:0] b;
    logic [7:0] res;
    logic [31:0] rd;
    logic err;
    logic trk;
    b = w | 8'h80;
    if (!b[3]) b[2] = 1'b0;
    res = (b[3] && !b[2] && neg) ? 8'h00 : code;
    sample_code <= code;
    sample_negative <= neg;
    apb(1'b1, adc_link_pkg::ADDR_CTRL, {24'h00_0000, w}, rd, err);
    trk = 1'b0;
    @(negedge clk_sys);
    while (conv_start !== 1'b1) begin
      trk = track;
      @(negedge clk_sys);
    end
    `CHK(trk, 1'b1)
    `CHK(track, 1'b0)
    `CHK({polarity_select, input_config_select, power_select, clock_mode_select}, b[3:0])
    `CHK(mux_pos, {b[5], b[4], b[6]})
    `CHK(mux_neg, b[2] ? 3'b000 : {b[5], b[4], ~b[6]})
    `CHK(mux_neg_common, b[2])
    `CHK({mux_neg_common4, mux_pos4}, {b[2], 1'b0, b[5], b[6]})
    `CHK(mux_neg4, b[2] ? 3'b000 : {1'b0, b[5], ~b[6]})
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0) begin
      apb(1'b0, adc_link_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
    end
    `CHK(rd[15:8], res)
  endtask

  // ==========================================
  // scenarios
  task automatic reg_map();
    logic [31:0] rd;
    logic err;
    apb(1'b0, adc_link_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 8'h08, 32'h0000_00FF, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h08, 32'h0000_0000, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask

  task automatic sel_sweep();
    for (int s = 0; s < 8; s++) begin
      convert({1'b1, 3'(s), 4'hF}, 8'hA5 ^ 8'(s), 1'b0);
      convert({1'b1, 3'(s), 4'hB}, 8'h3C + 8'(s), 1'b0);
    end
  endtask

  // unipolar differential with a negative input must give code zero
  task automatic uni_diff_negative();
    convert(8'hFB, 8'h77, 1'b1);
  endtask

  // start bit left out and bipolar single-ended asked: host must repair both
  task automatic bipolar_internal();
    convert(8'h34, 8'h81, 1'b1);
    convert(8'h5E, 8'h42, 1'b0);
  endtask

  // a second start while busy is dropped, and idle time starts nothing
  task automatic no_byte_no_conversion();
    logic [31:0] rd;
    logic err;
    int seen;
    seen = 0;
    apb(1'b1, adc_link_pkg::ADDR_CTRL, 32'h0000_00FF, rd, err);
    apb(1'b1, adc_link_pkg::ADDR_CTRL, 32'h0000_00FF, rd, err);
    `CHK(err, 1'b0)
    repeat (1900) begin
      @(negedge clk_sys);
      if (conv_start === 1'b1) seen++;
    end
    `CHK(seen, 1)
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reg_map();
    sel_sweep();
    uni_diff_negative();
    bipolar_internal();
    no_byte_no_conversion();
    stop_test();
  end
endmodule // tb
